// ---- pmc_defs.vh ----
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define PMC_ADDR_CTRL     8'h00
`define PMC_ADDR_CONFIG   8'h04
`define PMC_ADDR_STATUS   8'h08
`define PMC_ADDR_FLASH    8'h0c
// ****************************************
// Control register fields
// ****************************************
`define PMC_CTRL_IDLE     0
`define PMC_CTRL_STOP     1
// ****************************************
// Config and flash register fields
// ****************************************
`define PMC_CFG_WAKE_LSB  0
`define PMC_CFG_WAKE_MSB  3
`define PMC_CFG_CLEAR     5
`define PMC_CFG_SUSPEND   6
`define PMC_CFG_SLEEP     7
`define PMC_FLASH_BYPASS  6
// ****************************************
// Status register fields
// ****************************************
`define PMC_STAT_SUP_EN   0
`define PMC_STAT_CMISS_EN 1
// ****************************************
// Wake source bits
// ****************************************
`define PMC_WK_CMP        0
`define PMC_WK_PMAT       1
`define PMC_WK_ALARM      2
`define PMC_WK_OSCF       3
`define PMC_WK_RSTPIN     4
`define PMC_NWAKE         4
// ****************************************
// Mode codes
// ****************************************
`define PMC_MODE_NORMAL   3'h0
`define PMC_MODE_IDLE     3'h1
`define PMC_MODE_STOP     3'h2
`define PMC_MODE_SUSPEND  3'h3
`define PMC_MODE_SLEEP    3'h4
// ****************************************
// Timing
// ****************************************
`define PMC_FLAG_HIDE_CYC 2'h2
`define PMC_SUP_DEFAULT   16'hffff
`define PMC_ZERO32        32'h0000_0000
`endif

// ---- pmc_properties.sv ----
`timescale 1ns/10ps
// ****************************************
// Power mode checker
// ****************************************
module pmc_properties (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire       IRQ_PEND_I,
  input wire       INSN_DONE_I,
  input wire       CPU_HALT_O,
  input wire       PREC_OSC_EN_O,
  input wire       SYSCLK_GATE_O,
  input wire       INT_OSC_EN_O,
  input wire       CORE_PWR_EN_O,
  input wire       RESUME_NEXT_O,
  input wire       SYS_RESET_REQ_O,
  input wire [2:0] MODE_O
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_range; MODE_O <= 3'h4; endproperty
  a_range: assert property (p_range) else $error("mode code");
  property p_halt; CPU_HALT_O == (MODE_O != 3'h0); endproperty
  a_halt: assert property (p_halt) else $error("halt vs mode");
  property p_prec; PREC_OSC_EN_O == (MODE_O <= 3'h1); endproperty
  a_prec: assert property (p_prec) else $error("precise osc");
  property p_gate;
    SYSCLK_GATE_O == (MODE_O == 3'h3 || MODE_O == 3'h4);
  endproperty
  a_gate: assert property (p_gate) else $error("clock gate");
  property p_osc;
    INT_OSC_EN_O == !(MODE_O == 3'h3 || MODE_O == 3'h4);
  endproperty
  a_osc: assert property (p_osc) else $error("internal osc");
  property p_pwr; CORE_PWR_EN_O == (MODE_O != 3'h4); endproperty
  a_pwr: assert property (p_pwr) else $error("core power");
  // Entry waits for the instruction to finish
  property p_enter; MODE_O == 3'h0 && !INSN_DONE_I |=> MODE_O == 3'h0;
  endproperty
  a_enter: assert property (p_enter) else $error("early entry");
  property p_idle;
    MODE_O == 3'h1 && IRQ_PEND_I && !SYS_RESET_REQ_O
      |=> MODE_O == 3'h0 && RESUME_NEXT_O;
  endproperty
  a_idle: assert property (p_idle) else $error("idle wake");
  property p_stop; MODE_O == 3'h2 && !SYS_RESET_REQ_O |=> MODE_O == 3'h2;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left");
  property p_rst; SYS_RESET_REQ_O |=> MODE_O == 3'h0 && !SYS_RESET_REQ_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset exit");
  property p_resume;
    RESUME_NEXT_O |-> MODE_O == 3'h0 && $past(MODE_O) != 3'h2
      && $past(MODE_O) != 3'h0;
  endproperty
  a_resume: assert property (p_resume) else $error("resume");
endmodule // pmc_properties

bind pmc_top pmc_properties u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .IRQ_PEND_I(IRQ_PEND_I), .INSN_DONE_I(INSN_DONE_I),
  .CPU_HALT_O(CPU_HALT_O), .PREC_OSC_EN_O(PREC_OSC_EN_O),
  .SYSCLK_GATE_O(SYSCLK_GATE_O), .CORE_PWR_EN_O(CORE_PWR_EN_O),
  .INT_OSC_EN_O(INT_OSC_EN_O),
  .RESUME_NEXT_O(RESUME_NEXT_O), .SYS_RESET_REQ_O(SYS_RESET_REQ_O),
  .MODE_O(MODE_O));

// ---- pmc_sync.v ----
`timescale 1ns/10ps
// ****************************************
// Two-flop synchroniser, one per bit
// ****************************************
module pmc_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_reg;  // First stage, read only by q_o

  // Two stages; reset to zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {WIDTH{1'b0}};
      q_o      <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // pmc_sync

// ---- pmc_top.v ----
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "pmc_defs.vh"
// Contract
// R1: Five modes; normal unless requested
// R2: Idle bit halts core after instruction
// R3: Idle keeps registers, peripherals running
// R4: Enabled interrupt clears idle, restarts core
// R5: Resume after idle at next instruction
// R6: Reset ending idle restarts at zero
// R7: Supervisory timer expiry resets out of idle
// R8: Software may disable timer before idle
// R9: Stop bit enters stop after instruction
// R10: Stop halts precise oscillator and core
// R11: Stop exits only through reset
// R12: Missing clock detector reset ends stop
// R13: Software clears flash bypass before sleeping
// R14: Suspend gates clock, stops oscillators
// R15: Sleep gates power, keeps clock oscillator
// R16: Comparator wake in sleep needs two-cell
// R17: Regulator, manager, clock always battery powered
// R18: Digital domain unpowered during sleep
// R19: Suspend requested by config suspend bit
// R20: Wake flags read zero two clocks
// R21: Software re-enables wakes with request
// R22: Refuse suspend/sleep while enabled flag set
// R23: Idle plus stop together means stop
module pmc_top #(
  parameter SUP_CYCLES = `PMC_SUP_DEFAULT
) (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  input  wire        HSEL_I,
  input  wire [31:0] HADDR_I,
  input  wire [1:0]  HTRANS_I,
  input  wire        HWRITE_I,
  input  wire [2:0]  HSIZE_I,
  input  wire [31:0] HWDATA_I,
  input  wire        HREADY_I,
  output reg  [31:0] HRDATA_O,
  output reg         HREADYOUT_O,
  output reg         HRESP_O,
  input  wire        IRQ_PEND_I,
  input  wire        INSN_DONE_I,
  input  wire        CMP_WAKE_I,
  input  wire        PMAT_WAKE_I,
  input  wire        ALARM_WAKE_I,
  input  wire        OSCF_WAKE_I,
  input  wire        RST_PIN_FALL_I,
  input  wire        TWO_CELL_I,
  input  wire        CLK_MISS_I,
  output reg         CPU_HALT_O,
  output reg         PREC_OSC_EN_O,
  output reg         SYSCLK_GATE_O,
  output reg         INT_OSC_EN_O,
  output reg         CORE_PWR_EN_O,
  output reg         RESUME_NEXT_O,
  output reg         SYS_RESET_REQ_O,
  output reg  [2:0]  MODE_O
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [5:0] sync_w;  // Pins cross two flops first
  pmc_sync #(.WIDTH(6)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     ({CLK_MISS_I, TWO_CELL_I, OSCF_WAKE_I, ALARM_WAKE_I,
               PMAT_WAKE_I, CMP_WAKE_I}),
    .q_o     (sync_w)
  );
  wire [3:0] wake_ev_w = sync_w[3:0];  // Wake source levels
  wire       two_cell_w = sync_w[4];   // Two-cell supply strap
  wire       cmiss_w    = sync_w[5];   // Missing clock fault

  // ****************************************
  // State
  // ****************************************
  reg [2:0]  mode_reg;         // Current power mode
  reg [2:0]  mode_next;        // Next power mode
  reg [1:0]  ctrl_bits_reg;    // Idle/stop select bits
  reg [3:0]  wake_en_reg;      // Wake source enables
  reg [4:0]  wake_flag_reg;    // Sticky wake flags
  reg        bypass_reg;       // Flash bypass bit
  reg        sup_en_reg;       // Supervisory timer enable
  reg        cmiss_en_reg;     // Missing clock detector enable
  reg [31:0] sup_cnt_reg;      // Supervisory timer count
  reg [1:0]  hide_cnt_reg;     // Flag hide window after wake
  reg        req_idle_reg;     // Pending idle request
  reg        req_stop_reg;     // Pending stop request
  reg        req_susp_reg;     // Pending suspend request
  reg        req_sleep_reg;    // Pending sleep request
  reg        wr_pend_reg;      // AHB write data phase
  reg        rd_pend_reg;      // AHB read data phase
  reg [7:0]  addr_reg;         // Latched address

  // Wake is enabled-and-pending; comparator in sleep valid only two-cell
  function [3:0] pmc_live_wake;
    input [3:0] ev;
    input [3:0] en;
    input       two_cell;
    input       in_sleep;
    begin
      pmc_live_wake = ev & en;
      if (in_sleep && !two_cell)
        pmc_live_wake[`PMC_WK_CMP] = 1'b0;  // [R16]
    end
  endfunction

  wire [3:0] live_w = pmc_live_wake(wake_ev_w, wake_en_reg, two_cell_w,
                                    mode_reg == `PMC_MODE_SLEEP);
  wire       any_wake_w = (|live_w) | RST_PIN_FALL_I;
  // Enabled flag still set blocks deep entry
  wire       deep_block_w =
    |(wake_flag_reg[`PMC_CFG_WAKE_MSB:`PMC_CFG_WAKE_LSB] & wake_en_reg);
  wire       sup_fire_w = sup_en_reg &&
                          (sup_cnt_reg >= SUP_CYCLES - 1);
  wire       wr_w = wr_pend_reg;
  wire       bus_ok_w = HSEL_I && HREADY_I && HTRANS_I[1];

  // ****************************************
  // Mode sequencer
  // ****************************************
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `PMC_MODE_NORMAL: begin
        // Requests take effect after the setting instruction
        if (INSN_DONE_I) begin
          if (req_stop_reg)
            mode_next = `PMC_MODE_STOP;          // [R9] [R23]
          else if (req_idle_reg)
            mode_next = `PMC_MODE_IDLE;          // [R2]
          else if (req_sleep_reg && !deep_block_w)
            mode_next = `PMC_MODE_SLEEP;         // [R15] [R22]
          else if (req_susp_reg && !deep_block_w)
            mode_next = `PMC_MODE_SUSPEND;       // [R19] [R22]
        end
      end
      `PMC_MODE_IDLE: begin
        if (IRQ_PEND_I)
          mode_next = `PMC_MODE_NORMAL;          // [R4]
      end
      `PMC_MODE_STOP: begin
        mode_next = `PMC_MODE_STOP;              // [R11]
      end
      `PMC_MODE_SUSPEND,
      `PMC_MODE_SLEEP: begin
        if (any_wake_w)
          mode_next = `PMC_MODE_NORMAL;          // [R14] [R15]
      end
      default: mode_next = `PMC_MODE_NORMAL;     // [R1]
    endcase
    // A reset request beats any request or wake, so outputs follow
    if (SYS_RESET_REQ_O)
      mode_next = `PMC_MODE_NORMAL;              // [R6] [R11]
  end

  // Mode register; resets leave every mode through reset request
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      mode_reg <= `PMC_MODE_NORMAL;              // [R1] [R6]
    else if (SYS_RESET_REQ_O)
      mode_reg <= `PMC_MODE_NORMAL;              // [R6] [R11]
    else
      mode_reg <= mode_next;
  end

  // ****************************************
  // Supervisory timer, runs in every mode while enabled
  // ****************************************
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      sup_cnt_reg <= `PMC_ZERO32;
    else if (!sup_en_reg || SYS_RESET_REQ_O)
      sup_cnt_reg <= `PMC_ZERO32;                // [R8]
    else
      sup_cnt_reg <= sup_cnt_reg + 32'h0000_0001;
  end

  // ****************************************
  // Software visible registers
  // ****************************************
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_bits_reg <= 2'h0;
      wake_en_reg   <= 4'h0;
      wake_flag_reg <= 5'h00;
      bypass_reg    <= 1'b0;
      sup_en_reg    <= 1'b0;
      cmiss_en_reg  <= 1'b0;
      req_idle_reg  <= 1'b0;
      req_stop_reg  <= 1'b0;
      req_susp_reg  <= 1'b0;
      req_sleep_reg <= 1'b0;
      hide_cnt_reg  <= 2'h0;
    end else begin
      // Flags always follow events; set wins over clear below
      if (wr_w && addr_reg == `PMC_ADDR_CONFIG &&
          HWDATA_I[`PMC_CFG_CLEAR])
        wake_flag_reg <= {RST_PIN_FALL_I, wake_ev_w};
      else
        wake_flag_reg <= wake_flag_reg | {RST_PIN_FALL_I, wake_ev_w};
      // Hide window opens on each deep-mode wake
      if ((mode_reg == `PMC_MODE_SUSPEND ||
           mode_reg == `PMC_MODE_SLEEP) &&
          mode_next == `PMC_MODE_NORMAL)
        hide_cnt_reg <= `PMC_FLAG_HIDE_CYC;      // [R20]
      else if (hide_cnt_reg != 2'h0)
        hide_cnt_reg <= hide_cnt_reg - 2'h1;
      // Interrupt wake clears idle bit by hardware
      if (mode_reg == `PMC_MODE_IDLE && IRQ_PEND_I)
        ctrl_bits_reg[`PMC_CTRL_IDLE] <= 1'b0;   // [R4] [R5]
      else if (wr_w && addr_reg == `PMC_ADDR_CTRL)
        ctrl_bits_reg <= HWDATA_I[`PMC_CTRL_STOP:`PMC_CTRL_IDLE];
      if (mode_next != `PMC_MODE_NORMAL) begin
        req_idle_reg  <= 1'b0;
        req_stop_reg  <= 1'b0;
        req_susp_reg  <= 1'b0;
        req_sleep_reg <= 1'b0;
      end else if (wr_w && addr_reg == `PMC_ADDR_CTRL) begin
        req_idle_reg <= HWDATA_I[`PMC_CTRL_IDLE];
        req_stop_reg <= HWDATA_I[`PMC_CTRL_STOP];
      end else if (wr_w && addr_reg == `PMC_ADDR_CONFIG) begin
        req_susp_reg  <= HWDATA_I[`PMC_CFG_SUSPEND];
        req_sleep_reg <= HWDATA_I[`PMC_CFG_SLEEP];
      end
      // Enables land in the same write as the request
      if (wr_w && addr_reg == `PMC_ADDR_CONFIG)
        wake_en_reg <= HWDATA_I[`PMC_CFG_WAKE_MSB:`PMC_CFG_WAKE_LSB]; // [R21]
      if (wr_w && addr_reg == `PMC_ADDR_FLASH)
        bypass_reg <= HWDATA_I[`PMC_FLASH_BYPASS];  // [R13]
      if (wr_w && addr_reg == `PMC_ADDR_STATUS) begin
        sup_en_reg   <= HWDATA_I[`PMC_STAT_SUP_EN];    // [R8]
        cmiss_en_reg <= HWDATA_I[`PMC_STAT_CMISS_EN];  // [R12]
      end
    end
  end

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= bus_ok_w && HWRITE_I;
      rd_pend_reg <= bus_ok_w && !HWRITE_I;
      if (bus_ok_w)
        addr_reg <= HADDR_I[7:0];
    end
  end

  // Read data registered; unmapped reads return zero
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O    <= `PMC_ZERO32;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;                       // Always OKAY
      HRDATA_O    <= `PMC_ZERO32;
      if (bus_ok_w && !HWRITE_I) begin
        case (HADDR_I[7:0])
          `PMC_ADDR_CTRL:
            HRDATA_O <= {30'h0, ctrl_bits_reg};
          `PMC_ADDR_CONFIG:
            // Flags hidden while the manager refreshes them
            HRDATA_O <= (hide_cnt_reg != 2'h0) ?
                        {24'h0, 3'h0, 1'b0, wake_en_reg} :     // [R20]
                        {24'h0, 3'h0, wake_flag_reg[4],
                         wake_flag_reg[3:0] | wake_en_reg};
          `PMC_ADDR_STATUS:
            HRDATA_O <= {24'h0, 2'h0, mode_reg, 1'b0,
                         cmiss_en_reg, sup_en_reg};
          `PMC_ADDR_FLASH:
            HRDATA_O <= {24'h0, 1'b0, bypass_reg, 6'h00};
          default:
            HRDATA_O <= `PMC_ZERO32;
        endcase
      end
    end
  end

  // ****************************************
  // Power and clock controls
  // ****************************************
  // Each output but SYS_RESET_REQ_O and RESUME_NEXT_O is a flop fed from next mode so it matches mode_reg
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MODE_O          <= `PMC_MODE_NORMAL;
      CPU_HALT_O      <= 1'b0;
      PREC_OSC_EN_O   <= 1'b1;
      SYSCLK_GATE_O   <= 1'b0;
      INT_OSC_EN_O    <= 1'b1;
      CORE_PWR_EN_O   <= 1'b1;
      RESUME_NEXT_O   <= 1'b0;
      SYS_RESET_REQ_O <= 1'b0;
    end else begin
      // Idle halts only the core; peripherals keep clocks [R3]
      CPU_HALT_O    <= mode_next != `PMC_MODE_NORMAL;  // [R2] [R10]
      PREC_OSC_EN_O <= mode_next == `PMC_MODE_NORMAL ||
                       mode_next == `PMC_MODE_IDLE;    // [R10]
      SYSCLK_GATE_O <= mode_next == `PMC_MODE_SUSPEND ||
                       mode_next == `PMC_MODE_SLEEP;   // [R14]
      INT_OSC_EN_O  <= !(mode_next == `PMC_MODE_SUSPEND ||
                         mode_next == `PMC_MODE_SLEEP); // [R14] [R15]
      // Core domain off in sleep; battery domain untouched
      CORE_PWR_EN_O <= mode_next != `PMC_MODE_SLEEP;   // [R15] [R17] [R18]
      MODE_O        <= mode_next;
      // One-cycle pulse: resume at next instruction, no reset
      // A reset exit restarts at zero, so it never resumes
      RESUME_NEXT_O <= mode_reg != `PMC_MODE_NORMAL &&
                       mode_reg != `PMC_MODE_STOP &&
                       !SYS_RESET_REQ_O &&
                       mode_next == `PMC_MODE_NORMAL;  // [R5] [R14]
      // Reset pulse; core restarts at address zero
      SYS_RESET_REQ_O <= !SYS_RESET_REQ_O &&
                         (sup_fire_w ||                // [R7]
                          (cmiss_en_reg && cmiss_w));  // [R12]
    end
  end
endmodule // pmc_top

// ---- testbench.sv ----
`timescale 1ns/10ps
// ****************************************
// Power mode controller bench
// ****************************************
module testbench;
  logic        CLK_I, RST_N_I, HSEL_I, HWRITE_I, IRQ_PEND_I, INSN_DONE_I;
  logic        RST_PIN_FALL_I, TWO_CELL_I, CLK_MISS_I;
  logic [31:0] HADDR_I, HWDATA_I, rd, cfg;
  logic [1:0]  HTRANS_I;
  logic [2:0]  HSIZE_I, m;
  logic [3:0]  src;                   // Wake event levels
  wire  [31:0] HRDATA_O;
  wire  [2:0]  MODE_O;
  wire         HREADYOUT_O, HRESP_O, SYS_RESET_REQ_O;
  int          n_mismatch, cmp_count, i, slp, tc;
  // Short timer count keeps the supervisory test brief
  pmc_top #(.SUP_CYCLES(16)) dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .IRQ_PEND_I(IRQ_PEND_I), .INSN_DONE_I(INSN_DONE_I),
    .CMP_WAKE_I(src[0]), .PMAT_WAKE_I(src[1]), .ALARM_WAKE_I(src[2]),
    .OSCF_WAKE_I(src[3]), .RST_PIN_FALL_I(RST_PIN_FALL_I),
    .TWO_CELL_I(TWO_CELL_I), .CLK_MISS_I(CLK_MISS_I),
    .CPU_HALT_O(), .PREC_OSC_EN_O(), .SYSCLK_GATE_O(), .INT_OSC_EN_O(),
    .CORE_PWR_EN_O(), .RESUME_NEXT_O(), .SYS_RESET_REQ_O(SYS_RESET_REQ_O),
    .MODE_O(MODE_O));
  // Clock at 50 MHz
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  // Expected mode from the latest request bits
  function automatic [2:0] model(input [31:0] ctrl, input [31:0] c);
    if (c[7]) return 3'h4;
    if (c[6]) return 3'h3;
    if (ctrl[1]) return 3'h2;
    return ctrl[0] ? 3'h1 : 3'h0;
  endfunction
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_mode(input [2:0] e);
    cmp_count++;
    if (MODE_O !== e) begin
      n_mismatch++;
      $display("BAD %0t mode %0h expected %0h", $time, MODE_O, e);
    end
  endtask
  task automatic chk_word(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t data %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask
  // One single transfer; waits on ready in both phases
  task automatic bus(input bit w, input [7:0] a, input [31:0] d,
                     output [31:0] q);
    int n;
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'h2;
    HADDR_I <= {24'h0, a};
    HWRITE_I <= w;
    n = 0;
    do begin @(posedge CLK_I); n++; end while (HREADYOUT_O !== 1'b1 && n < 50);
    if (HREADYOUT_O !== 1'b1) n_mismatch++;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    n = 0;
    do begin @(posedge CLK_I); n++; end while (HREADYOUT_O !== 1'b1 && n < 50);
    if (HREADYOUT_O !== 1'b1) n_mismatch++;
    q = HRDATA_O;
  endtask
  // Bounded wait for a mode, then compare
  task automatic wait_mode(input [2:0] e);
    int n;
    n = 0;
    while (MODE_O !== e && n < 40) begin @(posedge CLK_I); n++; end
    chk_mode(e);
  endtask
  // Request a mode, then hold off any re-entry after the wake
  task automatic enter(input [7:0] a, input [31:0] d, input [2:0] e);
    bus(1'b1, a, d, rd);
    wait_mode(e);
    INSN_DONE_I <= 1'b0;
  endtask
  // Drop every request and enable, clear flags
  task automatic settle;
    bus(1'b1, 8'h00, 32'h0, rd);
    bus(1'b1, 8'h08, 32'h0, rd);
    bus(1'b1, 8'h0c, 32'h0, rd);
    bus(1'b1, 8'h04, 32'h20, rd);
    INSN_DONE_I <= 1'b1;
  endtask
  task automatic pin;
    @(posedge CLK_I) RST_PIN_FALL_I <= 1'b1;
    @(posedge CLK_I) RST_PIN_FALL_I <= 1'b0;
  endtask
  // Watchdog against a hang
  initial begin
    #400000;
    n_mismatch++;
    results;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {HSEL_I, HWRITE_I, IRQ_PEND_I, RST_PIN_FALL_I, CLK_MISS_I} = '0;
    {HADDR_I, HWDATA_I, HTRANS_I, src, TWO_CELL_I} = '0;
    HSIZE_I = 3'h2;
    INSN_DONE_I = 1'b1;
    RST_N_I = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(21391));
    cyc(2);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    chk_mode(3'h0);
    bus(1'b1, 8'h10, 32'hffff_ffff, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk_word(rd, 32'h0);
    INSN_DONE_I <= 1'b0;
    bus(1'b1, 8'h00, 32'h1, rd);
    cyc(4);
    chk_mode(3'h0);
    INSN_DONE_I <= 1'b1;
    wait_mode(model(32'h1, 32'h0));
    bus(1'b0, 8'h08, 32'h0, rd);
    chk_word(rd & 32'h38, 32'h8);
    IRQ_PEND_I <= 1'b1;
    @(posedge CLK_I) IRQ_PEND_I <= 1'b0;
    wait_mode(3'h0);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk_word(rd & 32'h1, 32'h0);
    enter(8'h00, 32'h3, model(32'h3, 32'h0));
    IRQ_PEND_I <= 1'b1;
    cyc(6);
    IRQ_PEND_I <= 1'b0;
    chk_mode(3'h2);
    bus(1'b1, 8'h08, 32'h2, rd);
    CLK_MISS_I <= 1'b1;
    wait_mode(3'h0);
    CLK_MISS_I <= 1'b0;
    settle;
    bus(1'b1, 8'h08, 32'h1, rd);
    enter(8'h00, 32'h1, 3'h1);
    wait_mode(3'h0);
    settle;
    // Each wake source, in suspend or sleep, the last two at random
    for (i = 0; i < 4; i++) begin
      // First source in one-cell sleep, second in suspend
      slp = (i < 2) ? 1 - i : $urandom % 2;
      tc = (i == 0) ? 0 : $urandom % 2;
      TWO_CELL_I <= tc[0];
      cfg = (32'h1 << i) | (slp ? 32'h80 : 32'h40);
      m = model(32'h0, cfg);
      enter(8'h04, cfg | 32'h20, m);
      src[i] <= 1'b1;
      if (slp == 1 && i == 0 && tc == 0) begin
        cyc(8);
        chk_mode(m);
        pin;
      end
      wait_mode(3'h0);
      settle;
      bus(1'b0, 8'h04, 32'h0, rd);
      chk_word(rd & 32'hf, 32'h1 << i);
      bus(1'b1, 8'h04, cfg, rd);
      cyc(6);
      chk_mode(3'h0);
      src[i] <= 1'b0;
      cyc(4);
      enter(8'h04, cfg | 32'h20, m);
      pin;
      wait_mode(3'h0);
      // Read at once: pin flag stays hidden, enables still show
      bus(1'b0, 8'h04, 32'h0, rd);
      chk_word(rd & 32'h1f, 32'h1 << i);
      settle;
    end
    // A reset in the middle of idle
    enter(8'h00, 32'h1, 3'h1);
    RST_N_I <= 1'b0;
    cyc(2);
    RST_N_I <= 1'b1;
    INSN_DONE_I <= 1'b1;
    @(posedge CLK_I);
    chk_mode(3'h0);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk_word(rd, 32'h0);
    results;
  end
endmodule // testbench
